// ===== sfpf_pin_front_end.sv
`timescale 1ns/10ps
module sfpf_pin_front_end #(
  parameter int ADDR_MSB = sfpf_pkg::ADDR_MSB_DEF
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // Serial pins
  input wire logic sckPin,
  input wire logic csPinN,
  input wire logic [3:0] dataLineIn,
  output logic [3:0] dataLineOut,
  output logic [3:0] dataLineOeN,
  // Configuration
  input wire logic quadPinsEnable,
  input wire logic pin3FunctionSelect,
  input wire logic statusLockBit,
  input wire logic fourLineCommandMode,
  input wire logic dualXfer,
  input wire logic quadXfer,
  // Core byte stream
  input wire logic [7:0] txByte,
  input wire logic txDrive,
  output logic txByteTaken,
  output logic [7:0] rxByte,
  output logic rxValid,
  // Status and pin roles
  output logic statusWrAllowed,
  output logic pauseMode,
  output logic resetMode,
  output logic selected,
  // Array decode
  input wire logic [sfpf_pkg::ADDR_W-1:0] arrayAddr,
  output logic [ADDR_MSB-sfpf_pkg::SECTOR_LSB:0] sectorNum,
  output logic [ADDR_MSB-sfpf_pkg::BLK32_LSB:0] block32Num,
  output logic [ADDR_MSB-sfpf_pkg::BLK64_LSB:0] block64Num
);

  if (ADDR_MSB < sfpf_pkg::BLK64_LSB || ADDR_MSB >= sfpf_pkg::ADDR_W) begin : g_addrChk
    $error("ADDR_MSB out of range");
  end

  function automatic logic [3:0] lineWidth(input logic dual, input logic quad);
    if (quad) begin
      return sfpf_pkg::WIDTH_QUAD;
    end else if (dual) begin
      return sfpf_pkg::WIDTH_DUAL;
    end
    return sfpf_pkg::WIDTH_SINGLE;
  endfunction : lineWidth

  // Top bits of a byte placed on the lines used by the width
  function automatic logic [3:0] placeChunk(input logic [7:0] b, input logic [3:0] w);
    if (w == sfpf_pkg::WIDTH_QUAD) begin
      return b[7:4];
    end else if (w == sfpf_pkg::WIDTH_DUAL) begin
      return {2'h0, b[7:6]};
    end
    return {2'h0, b[7], 1'b0};
  endfunction : placeChunk

  function automatic logic [3:0] lineMask(input logic [3:0] w);
    if (w == sfpf_pkg::WIDTH_QUAD) begin
      return 4'hf;
    end else if (w == sfpf_pkg::WIDTH_DUAL) begin
      return 4'h3;
    end
    return 4'h2;
  endfunction : lineMask

  // Synchroniser: three stages, a level counts once stages two and three agree
  logic [5:0] sync1_ff, sync2_ff, sync3_ff, pinLvl_ff;
  logic [5:0] nxt_pinLvl;

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      nxt_pinLvl[i] = (sync2_ff[i] == sync3_ff[i]) ? sync3_ff[i] : pinLvl_ff[i];
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= sfpf_pkg::PIN_LVL_RST;
      sync2_ff <= sfpf_pkg::PIN_LVL_RST;
      sync3_ff <= sfpf_pkg::PIN_LVL_RST;
      pinLvl_ff <= sfpf_pkg::PIN_LVL_RST;
    end else begin
      sync1_ff <= {dataLineIn, csPinN, sckPin};
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      pinLvl_ff <= nxt_pinLvl;
    end
  end

  logic sckRise, sckFall, csLvl;
  logic [3:0] ioLvl;
  assign sckRise = nxt_pinLvl[sfpf_pkg::PIN_SCK] && !pinLvl_ff[sfpf_pkg::PIN_SCK];
  assign sckFall = !nxt_pinLvl[sfpf_pkg::PIN_SCK] && pinLvl_ff[sfpf_pkg::PIN_SCK];
  assign csLvl = nxt_pinLvl[sfpf_pkg::PIN_CS];
  assign ioLvl = nxt_pinLvl[sfpf_pkg::PIN_IO0 +: 4];

  // Pin roles
  logic pauseReq, hwResetReq, protectLow, quadLines;
  logic [3:0] width;
  assign pauseReq = !quadPinsEnable && !pin3FunctionSelect && !ioLvl[3];
  assign hwResetReq = !quadPinsEnable && pin3FunctionSelect && !ioLvl[3];
  assign protectLow = !quadPinsEnable && !ioLvl[2];
  // Quad lines need pins three and four freed from their other roles
  assign quadLines = quadPinsEnable && (quadXfer || fourLineCommandMode);
  assign width = lineWidth(dualXfer, quadLines);

  // Link state
  sfpf_pkg::sfpf_state_e state_ff, nxt_state;
  logic armed_ff, nxt_armed, paused_ff, nxt_paused, inReset_ff, nxt_inReset;

  always_comb begin
    // Power-up: chip select must be seen high before a select counts
    nxt_armed = armed_ff || csLvl;
    if (hwResetReq) begin
      nxt_state = sfpf_pkg::ST_HWRESET;
    end else if (csLvl || !armed_ff) begin
      nxt_state = sfpf_pkg::ST_DESEL;
    end else if (pauseReq) begin
      nxt_state = sfpf_pkg::ST_PAUSED;
    end else begin
      nxt_state = sfpf_pkg::ST_ACTIVE;
    end
    nxt_paused = (nxt_state == sfpf_pkg::ST_PAUSED);
    nxt_inReset = (nxt_state == sfpf_pkg::ST_HWRESET);
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_ff <= sfpf_pkg::ST_DESEL;
      armed_ff <= 1'b0;
      paused_ff <= 1'b0;
      inReset_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      armed_ff <= nxt_armed;
      paused_ff <= nxt_paused;
      inReset_ff <= nxt_inReset;
    end
  end

  // Shift datapath
  logic [7:0] rxShift_ff, nxt_rxShift, txShift_ff, nxt_txShift, rxByte_ff, nxt_rxByte;
  logic [3:0] rxCnt_ff, nxt_rxCnt, txCnt_ff, nxt_txCnt;
  logic [3:0] out_ff, nxt_out, oeN_ff, nxt_oeN;
  logic rxValid_ff, nxt_rxValid, taken_ff, nxt_taken;
  logic [7:0] shifted;
  logic [3:0] sum;

  always_comb begin
    nxt_rxShift = rxShift_ff;
    nxt_rxCnt = rxCnt_ff;
    nxt_rxByte = rxByte_ff;
    nxt_rxValid = 1'b0;
    nxt_txShift = txShift_ff;
    nxt_txCnt = txCnt_ff;
    nxt_out = out_ff;
    nxt_taken = 1'b0;
    nxt_oeN = sfpf_pkg::OE_ALL_OFF;
    shifted = sfpf_pkg::BYTE_RST;
    sum = sfpf_pkg::CNT_RST;
    unique case (nxt_state)
      sfpf_pkg::ST_ACTIVE: begin
        if (sckRise) begin
          // Sample on rising edge, MSB first
          unique case (width)
            sfpf_pkg::WIDTH_QUAD: shifted = {rxShift_ff[3:0], ioLvl};
            sfpf_pkg::WIDTH_DUAL: shifted = {rxShift_ff[5:0], ioLvl[1:0]};
            default: shifted = {rxShift_ff[6:0], ioLvl[0]};
          endcase
          sum = rxCnt_ff + width;
          if (sum >= sfpf_pkg::BYTE_CNT) begin
            nxt_rxByte = shifted;
            nxt_rxValid = 1'b1;
            nxt_rxCnt = sfpf_pkg::CNT_RST;
          end else begin
            nxt_rxCnt = sum;
          end
          nxt_rxShift = shifted;
        end
        if (sckFall && txDrive) begin
          // Drive from falling edge; a new byte is taken at each byte start
          if (txCnt_ff == sfpf_pkg::CNT_RST) begin
            nxt_out = placeChunk(txByte, width);
            nxt_txShift = txByte << width;
            nxt_txCnt = sfpf_pkg::BYTE_CNT - width;
            nxt_taken = 1'b1;
          end else begin
            nxt_out = placeChunk(txShift_ff, width);
            nxt_txShift = txShift_ff << width;
            nxt_txCnt = txCnt_ff - width;
          end
        end
        if (txDrive) begin
          nxt_oeN = ~lineMask(width);
        end
      end
      sfpf_pkg::ST_PAUSED: begin
        // Everything holds, output released
        nxt_oeN = sfpf_pkg::OE_ALL_OFF;
      end
      default: begin
        // Deselect or hardware reset ends the sequence
        nxt_rxShift = sfpf_pkg::BYTE_RST;
        nxt_rxCnt = sfpf_pkg::CNT_RST;
        nxt_txShift = sfpf_pkg::BYTE_RST;
        nxt_txCnt = sfpf_pkg::CNT_RST;
        nxt_out = sfpf_pkg::OUT_RST;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rxShift_ff <= sfpf_pkg::BYTE_RST;
      rxCnt_ff <= sfpf_pkg::CNT_RST;
      rxByte_ff <= sfpf_pkg::BYTE_RST;
      rxValid_ff <= 1'b0;
      txShift_ff <= sfpf_pkg::BYTE_RST;
      txCnt_ff <= sfpf_pkg::CNT_RST;
      out_ff <= sfpf_pkg::OUT_RST;
      oeN_ff <= sfpf_pkg::OE_ALL_OFF;
      taken_ff <= 1'b0;
    end else begin
      rxShift_ff <= nxt_rxShift;
      rxCnt_ff <= nxt_rxCnt;
      rxByte_ff <= nxt_rxByte;
      rxValid_ff <= nxt_rxValid;
      txShift_ff <= nxt_txShift;
      txCnt_ff <= nxt_txCnt;
      out_ff <= nxt_out;
      oeN_ff <= nxt_oeN;
      taken_ff <= nxt_taken;
    end
  end

  // Status protection and array decode
  logic wrAllowed_ff, nxt_wrAllowed;
  logic [ADDR_MSB-sfpf_pkg::SECTOR_LSB:0] sector_ff, nxt_sector;
  logic [ADDR_MSB-sfpf_pkg::BLK32_LSB:0] blk32_ff, nxt_blk32;
  logic [ADDR_MSB-sfpf_pkg::BLK64_LSB:0] blk64_ff, nxt_blk64;

  always_comb begin
    // Protect pin is ignored once it serves as a data line
    nxt_wrAllowed = !(statusLockBit && protectLow);
    nxt_sector = arrayAddr[ADDR_MSB:sfpf_pkg::SECTOR_LSB];
    nxt_blk32 = arrayAddr[ADDR_MSB:sfpf_pkg::BLK32_LSB];
    nxt_blk64 = arrayAddr[ADDR_MSB:sfpf_pkg::BLK64_LSB];
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      wrAllowed_ff <= 1'b1;
      sector_ff <= '0;
      blk32_ff <= '0;
      blk64_ff <= '0;
    end else begin
      wrAllowed_ff <= nxt_wrAllowed;
      sector_ff <= nxt_sector;
      blk32_ff <= nxt_blk32;
      blk64_ff <= nxt_blk64;
    end
  end

  assign dataLineOut = out_ff;
  assign dataLineOeN = oeN_ff;
  assign txByteTaken = taken_ff;
  assign rxByte = rxByte_ff;
  assign rxValid = rxValid_ff;
  assign statusWrAllowed = wrAllowed_ff;
  assign pauseMode = paused_ff;
  assign resetMode = inReset_ff;
  assign selected = state_ff[0];
  assign sectorNum = sector_ff;
  assign block32Num = blk32_ff;
  assign block64Num = blk64_ff;

  // Checks
  quad_no_protect_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    quadPinsEnable && $stable(quadPinsEnable) |=> statusWrAllowed)
    else $error("protect pin honoured while quad pins enabled");

  quad_no_hold_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    quadPinsEnable |=> !pauseMode && !resetMode)
    else $error("pause or reset active while quad pins enabled");

  pin4_role_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pauseMode |-> !$past(pin3FunctionSelect) && !$past(quadPinsEnable))
    else $error("pause mode with reset function selected");

  pause_freeze_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pauseMode ##1 pauseMode |-> $stable(rxCnt_ff) && $stable(rxShift_ff) && !rxValid)
    else $error("transfer state moved during pause");

  pause_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    pauseMode |-> dataLineOeN == sfpf_pkg::OE_ALL_OFF)
    else $error("output driven during pause");

  reset_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    resetMode |-> dataLineOeN == sfpf_pkg::OE_ALL_OFF && rxCnt_ff == sfpf_pkg::CNT_RST)
    else $error("outputs or state live in reset mode");

  rise_sample_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    rxValid |-> pinLvl_ff[sfpf_pkg::PIN_SCK] && !$past(pinLvl_ff[sfpf_pkg::PIN_SCK]))
    else $error("byte completed without a rising clock edge");
  block_align_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    block32Num == sectorNum[ADDR_MSB-sfpf_pkg::SECTOR_LSB:3]
      && block64Num == sectorNum[ADDR_MSB-sfpf_pkg::SECTOR_LSB:4])
    else $error("block number not aligned to sector groups");
  desel_hiz_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    !armed_ff || pinLvl_ff[sfpf_pkg::PIN_CS] |-> !selected
      && dataLineOeN == sfpf_pkg::OE_ALL_OFF && !rxValid)
    else $error("active while deselected or before first select");

  lock_refuse_a: assert property (@(posedge sys_clk) disable iff (!nrst)
    statusLockBit && !quadPinsEnable && !ioLvl[2] && $stable(statusLockBit)
      |=> !statusWrAllowed)
    else $error("status write allowed with lock and protect low");

endmodule : sfpf_pin_front_end

// ===== sfpf_pkg.sv
package sfpf_pkg;

  // Input synchroniser depth and byte framing
  localparam int SYNC_STAGES = 3;
  localparam int BYTE_BITS = 8;

  // Array address split: 4 KB sectors, 32 KB and 64 KB blocks
  localparam int ADDR_W = 24;
  localparam int ADDR_MSB_DEF = 19;
  localparam int SECTOR_LSB = 12;
  localparam int BLK32_LSB = 15;
  localparam int BLK64_LSB = 16;

  // Line widths of a transfer
  localparam logic [3:0] WIDTH_SINGLE = 4'h1;
  localparam logic [3:0] WIDTH_DUAL = 4'h2;
  localparam logic [3:0] WIDTH_QUAD = 4'h4;
  localparam logic [3:0] BYTE_CNT = 4'h8;

  // Reset values
  localparam logic [3:0] OE_ALL_OFF = 4'hf;
  localparam logic [3:0] OUT_RST = 4'h0;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  // Select starts low so that only a real high can arm the first select
  localparam logic [5:0] PIN_LVL_RST = 6'h3d;

  // Pin vector positions in the synchroniser
  localparam int PIN_SCK = 0;
  localparam int PIN_CS = 1;
  localparam int PIN_IO0 = 2;

  typedef enum logic [1:0] {
    ST_DESEL = 2'b00,
    ST_ACTIVE = 2'b01,
    ST_PAUSED = 2'b11,
    ST_HWRESET = 2'b10
  } sfpf_state_e;

endpackage : sfpf_pkg

// ===== sfpf_spi_master.sv
`timescale 1ns/10ps
// Master on the far side; clock toggles in shift and is set to the mode idle level at frame start and end; the test also runs shift outside frames
module sfpf_spi_master (
  // Clock
  input wire logic sys_clk,
  // Link pins
  output logic sck,
  output logic csN,
  output logic [3:0] drv,
  input wire logic [3:0] line
);
  initial begin
    sck = 1'b0;
    csN = 1'b1;
    drv = 4'ha;
  end
  // Half period of 100 ns, stepped just after the system edge
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #2;
  endtask : half
  task automatic startFrame(input bit mode3);
    sck = mode3;
    half();
    csN = 1'b0;
    half();
  endtask : startFrame
  // Read back late in the high phase, safe against pin latency
  task automatic shift(input logic [7:0] v, input int steps, input int w,
      output logic [7:0] got);
    got = 8'h00;
    for (int s = 0; s < steps; s++) begin
      sck = 1'b0;
      drv = (w == 4) ? v[7:4] : (w == 2) ? {2'b00, v[7:6]} : {3'b000, v[7]};
      v = v << w;
      half();
      sck = 1'b1;
      half();
      got = {got[6:0], line[1]};
    end
  endtask : shift
  task automatic endFrame(input bit mode3);
    sck = mode3;
    half();
    csN = 1'b1;
    // Released lines must not keep the last value
    drv = ~drv;
    half();
  endtask : endFrame
endmodule : sfpf_spi_master

// ===== tb.sv
`timescale 1ns/10ps
module tb;
  logic sys_clk, nrst, quadEn, fnSel, lock, four_line_command_mode, dual, quad, txDrive, prot, hold;
  logic sck, csN, taken, rxValid, wrOk, pauseM, rstM, sel;
  logic [7:0] txByte, got, b, rxByte, secN;
  logic [23:0] addr;
  logic [3:0] dOut, dOeN, line, drv, b64;
  logic [4:0] b32;
  logic [3:0] cfgs [4] = '{4'b0010, 4'b1001, 4'b1100, 4'b0001};
  int steps [4] = '{4, 2, 2, 8};
  int n_mismatch = 0;
  int comparisons = 0;
  int nTaken = 0;
  int r, j;
  logic [7:0] rxq [$];
  sfpf_pin_front_end uut (.sys_clk(sys_clk), .nrst(nrst), .sckPin(sck), .csPinN(csN),
    .dataLineIn(line), .dataLineOut(dOut), .dataLineOeN(dOeN), .quadPinsEnable(quadEn),
    .pin3FunctionSelect(fnSel), .statusLockBit(lock), .fourLineCommandMode(four_line_command_mode),
    .dualXfer(dual), .quadXfer(quad), .txByte(txByte), .txDrive(txDrive),
    .txByteTaken(taken), .rxByte(rxByte), .rxValid(rxValid), .statusWrAllowed(wrOk),
    .pauseMode(pauseM), .resetMode(rstM), .selected(sel), .arrayAddr(addr),
    .sectorNum(secN), .block32Num(b32), .block64Num(b64));
  sfpf_spi_master m (.sys_clk(sys_clk), .sck(sck), .csN(csN), .drv(drv), .line(line));
  // Wire level: device first, then master, pins 2 and 3 by role
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      line[i] = !dOeN[i] ? dOut[i] : drv[i];
    end
    if (!quadEn && dOeN[2]) line[2] = prot;
    if (!quadEn && dOeN[3]) line[3] = hold;
  end
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (rxValid === 1'b1) rxq.push_back(rxByte);
  always @(posedge sys_clk) if (taken === 1'b1) nTaken++;
  task automatic summarize();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : tick
  task automatic getRx(input logic [7:0] exp);
    int k;
    k = 0;
    while (rxq.size() == 0 && k < 40) begin
      tick(1);
      k++;
    end
    if (rxq.size() == 0) begin
      n_mismatch++;
      $display("BAD %0t no byte", $time);
      summarize();
    end else begin
      check(rxq.pop_front(), exp);
    end
  endtask : getRx
  initial begin
    {nrst, quadEn, fnSel, lock, four_line_command_mode, dual, quad, txDrive, prot, hold} = 10'h003;
    txByte = 8'h00;
    addr = 24'h000000;
    void'($urandom(53));
    tick(2);
    nrst = 1'b1;
    check({4'h0, dOeN}, 8'h0f);
    check({5'h0, sel, rstM, wrOk}, 8'h01);
    for (int i = 0; i < 8; i++) begin
      addr = (i == 0) ? 24'h0fffff : 24'($urandom);
      tick(2);
      check(secN, 8'(addr / 4096));
      check({3'h0, b32}, 8'(5'(addr / 32768)));
      check({4'h0, b64}, 8'(4'(addr / 65536)));
    end
    for (int md = 0; md < 2; md++) begin
      m.startFrame(md[0]);
      for (int k = 0; k < 2; k++) begin
        b = 8'($urandom);
        m.shift(b, 8, 1, got);
        getRx(b);
      end
      m.endFrame(md[0]);
    end
    m.shift(8'h5a, 8, 1, got);
    tick(8);
    check(8'(rxq.size()), 8'h00);
    r = $urandom % 4;
    for (int c = 0; c < 4; c++) begin
      j = (c + r) % 4;
      {quadEn, four_line_command_mode, dual, quad} = cfgs[j];
      tick(1);
      m.startFrame(1'b0);
      b = 8'($urandom);
      m.shift(b, steps[j], 8 / steps[j], got);
      getRx(b);
      m.endFrame(1'b0);
    end
    {quadEn, four_line_command_mode, dual, quad} = 4'h0;
    txDrive = 1'b1;
    txByte = 8'($urandom);
    m.startFrame(1'b1);
    m.shift(8'h00, 8, 1, got);
    check(got, txByte);
    m.endFrame(1'b1);
    getRx(8'h00);
    check(8'(nTaken), 8'h01);
    check({4'h0, dOeN}, 8'h0f);
    // Pause mid byte: clock edges while paused must not count
    m.startFrame(1'b0);
    b = 8'($urandom);
    m.shift(b, 4, 1, got);
    check({7'h0, dOeN[1]}, 8'h00);
    hold = 1'b0;
    tick(6);
    check({6'h0, pauseM, sel}, 8'h03);
    check({4'h0, dOeN}, 8'h0f);
    m.shift(8'hff, 2, 1, got);
    hold = 1'b1;
    tick(6);
    m.shift(b << 4, 4, 1, got);
    getRx(b);
    m.endFrame(1'b0);
    txDrive = 1'b0;
    hold = 1'b0;
    for (int c = 0; c < 3; c++) begin
      {quadEn, fnSel} = (c == 0) ? 2'b01 : (c == 1) ? 2'b11 : 2'b00;
      tick(6);
      check({7'h0, rstM}, 8'(c == 0));
      check({4'h0, dOeN}, 8'h0f);
    end
    hold = 1'b1;
    r = $urandom % 8;
    for (int c = 0; c < 8; c++) begin
      {lock, prot, quadEn} = 3'(c ^ r);
      tick(6);
      check({7'h0, wrOk}, 8'(!(lock && !prot && !quadEn)));
    end
    // Select held low through a reset must not count as a first select
    {lock, prot, quadEn} = 3'b010;
    nrst = 1'b0;
    m.startFrame(1'b0);
    nrst = 1'b1;
    b = 8'($urandom);
    m.shift(b, 8, 1, got);
    tick(8);
    check(8'(rxq.size()), 8'h00);
    check({7'h0, sel}, 8'h00);
    m.endFrame(1'b0);
    m.startFrame(1'b0);
    m.shift(b, 8, 1, got);
    getRx(b);
    m.endFrame(1'b0);
    summarize();
  end
endmodule : tb
